// ---- hw/bsc_bus_stretch_controller.sv ----
// Bus stretch controller: control register, Avalon slave and wait-state sequencer
//
// The Avalon-MM slave port was decided locally.
`include "bsc_cfg.svh"
`default_nettype none

module bsc_bus_stretch_controller
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [`BSC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hwStandbyN,
    input wire logic cycStart,
    input wire logic cycExternal,
    input wire logic stretchReqN,
    output bsc_pkg::bsc_state_t busState,
    output logic waitInsert,
    output logic cycDone,
    output logic periphTick,
    output logic periphClockHalve,
    output logic flashRegsEnable,
    output logic emuRamSelect,
    output logic emuRamArea
);
    import bsc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic waitReq_q;
    logic [31:0] readData_q;
    logic busReq;
    logic ctrlHit;
    logic ctrlWrite;
    bsc_state_t state_q;
    bsc_state_t state_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    bsc_mode_t cycMode_q;
    logic [1:0] cycCount_q;
    logic cycExt_q;
    logic reqLow;
    logic waitIns_q;
    logic done_q;
    logic phase_q;
    logic tick_q;
    logic cycAccept;

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    assign busReq = avs_read | avs_write;
    assign ctrlHit = (avs_address == `BSC_CTRL_ADDR);
    // A write lands only on the edge where the master sees waitrequest low
    assign ctrlWrite = avs_write & ~waitReq_q & ctrlHit & avs_byteenable[0];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitReq_q <= 1'b1;
        end
        else if (busReq && waitReq_q)
        begin
            waitReq_q <= 1'b0;
        end
        else
        begin
            waitReq_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            readData_q <= 32'h0000_0000;
        end
        else if (avs_read && waitReq_q)
        begin
            // Unmapped reads answer zero; upper bits always read zero
            readData_q <= ctrlHit ? {24'h00_0000, ctrl_q} : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Software standby has no port here: contents simply hold through it
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `BSC_CTRL_RESET;
        end
        else if (!hwStandbyN)
        begin
            ctrl_q <= `BSC_CTRL_RESET;
        end
        else if (ctrlWrite)
        begin
            // All eight bits store and read back
            ctrl_q <= avs_writedata[7:0];
        end
    end

    // ****************************************************************
    // Side bits driven out of the register
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            periphClockHalve <= 1'b0;
            flashRegsEnable <= 1'b0;
            emuRamSelect <= 1'b0;
            emuRamArea <= 1'b0;
        end
        else
        begin
            periphClockHalve <= ctrl_q[`BSC_HALVE_BIT];
            flashRegsEnable <= ctrl_q[`BSC_FLASH_BIT];
            emuRamSelect <= ctrl_q[`BSC_SEL_BIT];
            emuRamArea <= ctrl_q[`BSC_AREA_BIT];
        end
    end

    // ****************************************************************
    // Peripheral clock enable
    // ****************************************************************
    // A tick per cycle, or every other cycle when halved; an enable
    // rather than a gated clock keeps the design on one clock tree
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= 1'b0;
            tick_q <= 1'b1;
        end
        else
        begin
            phase_q <= ctrl_q[`BSC_HALVE_BIT] ? ~phase_q : 1'b0;
            tick_q <= ~ctrl_q[`BSC_HALVE_BIT] | phase_q;
        end
    end

    // ****************************************************************
    // Request pin sampler
    // ****************************************************************
    bsc_wait_sampler u_sampler
    (
        .mclk(mclk),
        .rstn(rstn),
        .stretchReqN(stretchReqN),
        .reqLow(reqLow)
    );

    // ****************************************************************
    // Cycle capture
    // ****************************************************************
    // New cycles start only from idle or the closing T3
    assign cycAccept = cycStart && (state_q == BSC_ST_IDLE || state_q == BSC_ST_T3);

    // Settings are frozen per cycle so a register write mid-cycle is harmless
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cycMode_q <= BSC_MODE_PIN;
            cycCount_q <= 2'h0;
            cycExt_q <= 1'b0;
        end
        else if (cycAccept)
        begin
            cycMode_q <= bsc_mode_t'(ctrl_q[`BSC_MODE_MSB:`BSC_MODE_LSB]);
            cycCount_q <= ctrl_q[`BSC_CNT_MSB:`BSC_CNT_LSB];
            cycExt_q <= cycExternal;
        end
    end

    // ****************************************************************
    // Wait-state sequencer
    // ****************************************************************
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            BSC_ST_IDLE:
            begin
                if (cycAccept)
                begin
                    state_d = BSC_ST_T1;
                end
            end
            BSC_ST_T1:
            begin
                state_d = BSC_ST_T2;
            end
            BSC_ST_T2:
            begin
                state_d = BSC_ST_T3;
                cnt_d = 2'h0;
                if (!cycExt_q)
                begin
                    state_d = BSC_ST_T3;
                end
                else
                begin
                    unique case (cycMode_q)
                        BSC_MODE_PROG:
                        begin
                            if (cycCount_q != 2'h0)
                            begin
                                state_d = BSC_ST_TW;
                                cnt_d = cycCount_q;
                            end
                        end
                        BSC_MODE_NONE:
                        begin
                            state_d = BSC_ST_T3;
                        end
                        BSC_MODE_PIN:
                        begin
                            // With a zero count, T2 acts as the last counted state
                            if (cycCount_q != 2'h0)
                            begin
                                state_d = BSC_ST_TW;
                                cnt_d = cycCount_q;
                            end
                            else if (reqLow)
                            begin
                                state_d = BSC_ST_TW;
                                cnt_d = 2'h1;
                            end
                        end
                        BSC_MODE_AUTO:
                        begin
                            if (reqLow && cycCount_q != 2'h0)
                            begin
                                state_d = BSC_ST_TW;
                                cnt_d = cycCount_q;
                            end
                        end
                    endcase
                end
            end
            BSC_ST_TW:
            begin
                if (cnt_q != 2'h1)
                begin
                    cnt_d = cnt_q - 2'h1;
                end
                else if (cycMode_q == BSC_MODE_PIN && reqLow)
                begin
                    cnt_d = 2'h1;
                end
                else
                begin
                    // Auto-wait ends here whatever the pin does
                    state_d = BSC_ST_T3;
                    cnt_d = 2'h0;
                end
            end
            BSC_ST_T3:
            begin
                state_d = cycAccept ? BSC_ST_T1 : BSC_ST_IDLE;
            end
            default:
            begin
                state_d = BSC_ST_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= BSC_ST_IDLE;
            cnt_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitIns_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            waitIns_q <= (state_d == BSC_ST_TW);
            done_q <= (state_d == BSC_ST_T3);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign busState = state_q;
    assign waitInsert = waitIns_q;
    assign cycDone = done_q;
    assign periphTick = tick_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_prog_exact_two: assert property (
        (state_q == BSC_ST_T2 && cycExt_q && cycMode_q == BSC_MODE_PROG && cycCount_q == 2'h2)
        |=> (state_q == BSC_ST_TW) [*2] ##1 (state_q == BSC_ST_T3))
        else $error("programmable mode did not insert two wait states");

    a_count_zero_skip: assert property (
        (state_q == BSC_ST_T2 && cycMode_q == BSC_MODE_PROG && cycCount_q == 2'h0)
        |=> state_q == BSC_ST_T3)
        else $error("zero count still inserted a wait state");

    a_none_mode_skip: assert property (
        (state_q == BSC_ST_T2 && cycMode_q == BSC_MODE_NONE) |=> state_q == BSC_ST_T3)
        else $error("no-wait mode inserted a wait state");

    a_internal_no_wait: assert property (
        (state_q == BSC_ST_T2 && !cycExt_q) |=> state_q == BSC_ST_T3)
        else $error("on-chip access was stretched");

    a_pin_extra_state: assert property (
        (state_q == BSC_ST_TW && cnt_q == 2'h1 && cycMode_q == BSC_MODE_PIN && reqLow)
        |=> state_q == BSC_ST_TW && waitInsert)
        else $error("pin wait did not add a state for a low request");

    a_pin_release: assert property (
        (state_q == BSC_ST_TW && cnt_q == 2'h1 && cycMode_q == BSC_MODE_PIN && !reqLow)
        |=> state_q == BSC_ST_T3 ##1 !waitInsert)
        else $error("pin wait did not end on a high request");

    a_auto_skip_high: assert property (
        (state_q == BSC_ST_T2 && cycExt_q && cycMode_q == BSC_MODE_AUTO && !reqLow)
        |=> state_q == BSC_ST_T3)
        else $error("auto-wait stretched with the request high");

    a_auto_bounded: assert property (
        (state_q == BSC_ST_T2 && cycExt_q && cycMode_q == BSC_MODE_AUTO && reqLow
         && cycCount_q == 2'h3)
        |=> (state_q == BSC_ST_TW) [*3] ##1 (state_q == BSC_ST_T3))
        else $error("auto-wait did not insert exactly three states");

    a_standby_reload: assert property (
        !hwStandbyN |=> ctrl_q == `BSC_CTRL_RESET)
        else $error("hardware standby did not reload the control register");

    a_write_stores: assert property (
        (hwStandbyN && ctrlWrite) |=> ctrl_q == $past(avs_writedata[7:0]))
        else $error("control register write was lost");

    // Judged on the register bit itself: the copied output and the divider both load from it at the same edge, a cycle behind it
    a_halve_tick: assert property (
        (ctrl_q[`BSC_HALVE_BIT] && $past(ctrl_q[`BSC_HALVE_BIT]) && periphTick)
        |=> !periphTick)
        else $error("halved peripheral tick came on two cycles running");

    a_bus_answer: assert property (
        (busReq && waitReq_q) |=> !avs_waitrequest)
        else $error("register bus request not answered in one cycle");

    c_prog_wait: cover property (
        state_q == BSC_ST_TW && cycMode_q == BSC_MODE_PROG);
    c_pin_extend: cover property (
        state_q == BSC_ST_TW && cycMode_q == BSC_MODE_PIN && cnt_q == 2'h1 && reqLow);
    c_auto_wait: cover property (
        state_q == BSC_ST_TW && cycMode_q == BSC_MODE_AUTO);
    c_ctrl_write: cover property (ctrlWrite);

endmodule // bsc_bus_stretch_controller

`default_nettype wire

// ---- hw/bsc_cfg.svh ----
// Offsets, field positions, reset value and timing counts of the bus stretch controller
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// ****************************************************************
// Register placement
// ****************************************************************
// Printed register index; the byte address on the bus is four times it
`define BSC_CTRL_INDEX 16'hFFC2
`define BSC_ADDR_W 18
`define BSC_CTRL_ADDR 18'h3FF08

// ****************************************************************
// Field positions of wait_state_control
// ****************************************************************
`define BSC_CNT_LSB 0
`define BSC_CNT_MSB 1
`define BSC_MODE_LSB 2
`define BSC_MODE_MSB 3
`define BSC_FLASH_BIT 4
`define BSC_HALVE_BIT 5
`define BSC_AREA_BIT 6
`define BSC_SEL_BIT 7

// ****************************************************************
// Reset value and timing
// ****************************************************************
`define BSC_CTRL_RESET 8'h08
// Register bus answers this many cycles after the request appears
`define BSC_ACK_CYCLES 1

`endif

// ---- hw/bsc_pkg.sv ----
// Types shared by the bus stretch controller files
`default_nettype none

package bsc_pkg;

    // ****************************************************************
    // Stretch modes, as coded in the mode field
    // ****************************************************************
    typedef enum logic [1:0] {
        BSC_MODE_PROG = 2'b00,
        BSC_MODE_NONE = 2'b01,
        BSC_MODE_PIN  = 2'b10,
        BSC_MODE_AUTO = 2'b11
    } bsc_mode_t;

    // ****************************************************************
    // External bus cycle states
    // ****************************************************************
    typedef enum logic [2:0] {
        BSC_ST_IDLE = 3'b000,
        BSC_ST_T1   = 3'b001,
        BSC_ST_T2   = 3'b010,
        BSC_ST_TW   = 3'b011,
        BSC_ST_T3   = 3'b100
    } bsc_state_t;

endpackage

`default_nettype wire

// ---- hw/bsc_wait_sampler.sv ----
// Falling-edge sampler of the active-low stretch request pin
`default_nettype none

module bsc_wait_sampler
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic stretchReqN,
    output logic reqLow
);

    // ****************************************************************
    // Sample at the clock fall
    // ****************************************************************
    // The pin is judged mid-state, so the state machine sees it at the
    // rising edge that closes the same state
    logic low_q;

    always_ff @(negedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_q <= 1'b0;
        end
        else
        begin
            low_q <= ~stretchReqN;
        end
    end

    assign reqLow = low_q;

endmodule // bsc_wait_sampler

`default_nettype wire

// ---- verification/bsc_slow_device.sv ----
// Slow external device model that drives the active-low stretch request pin
`default_nettype none

module bsc_slow_device
(
    input wire logic mclk,
    input wire logic rstn,
    input wire bsc_pkg::bsc_state_t busState,
    input wire logic [2:0] lowCount,
    output logic stretchReqN
);
    import bsc_pkg::*;

    logic [2:0] remain_q;

    // ****************************************************************
    // Request pin
    // ****************************************************************
    // Pin has a pull-up, so a released pin reads high
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            remain_q <= 3'h0;
            stretchReqN <= 1'b1;
        end
        else if (busState == BSC_ST_T1)
        begin
            // Held low from T2 on, as a chip select routed to the pin would be
            // The bench sets lowCount to 5 for internal cycles too, to show the pin is ignored
            remain_q <= lowCount;
            stretchReqN <= (lowCount == 3'h0);
        end
        else if (remain_q != 3'h0)
        begin
            remain_q <= remain_q - 3'h1;
            stretchReqN <= (remain_q <= 3'h1);
        end
        else
        begin
            stretchReqN <= 1'b1;
        end
    end

endmodule // bsc_slow_device

`default_nettype wire

// ---- verification/test_external_bus_wait_state_control.sv ----
// Self-checking testbench of the bus stretch controller
`include "bsc_cfg.svh"
`default_nettype none

module test_external_bus_wait_state_control;
    import bsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic rstn;
    logic [`BSC_ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hwStandbyN;
    logic cycStart;
    logic cycExternal;
    logic stretchReqN;
    bsc_state_t busState;
    logic waitInsert;
    logic cycDone;
    logic periphTick;
    logic periphClockHalve;
    logic flashRegsEnable;
    logic emuRamSelect;
    logic emuRamArea;
    logic [2:0] lowCount;
    logic [31:0] rd;
    logic t0;
    int n_fail;
    int tests_run;
    int lows[3] = '{0, 2, 5};

    bsc_bus_stretch_controller dut
    (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hwStandbyN(hwStandbyN), .cycStart(cycStart),
        .cycExternal(cycExternal), .stretchReqN(stretchReqN), .busState(busState),
        .waitInsert(waitInsert), .cycDone(cycDone), .periphTick(periphTick),
        .periphClockHalve(periphClockHalve), .flashRegsEnable(flashRegsEnable),
        .emuRamSelect(emuRamSelect), .emuRamArea(emuRamArea)
    );

    bsc_slow_device partner
    (
        .mclk(mclk), .rstn(rstn), .busState(busState), .lowCount(lowCount),
        .stretchReqN(stretchReqN)
    );

    // ****************************************************************
    // Compare and access tasks
    // ****************************************************************
    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Request held until a rising edge samples waitrequest low; data taken at that edge
    task automatic bus_access(input logic wr, input logic [`BSC_ADDR_W-1:0] addr,
        input logic [7:0] data, input logic [3:0] be, output logic [31:0] rdata);
        int k;
        @(posedge mclk);
        avs_address <= addr;
        avs_writedata <= {24'h0, data};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        check_bit("bus answer", 1'b1, avs_waitrequest === 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic bus_cycle(input logic ext, input int n, input int expTw);
        int tw;
        int k;
        tw = 0;
        @(posedge mclk);
        cycStart <= 1'b1;
        cycExternal <= ext;
        lowCount <= 3'(n);
        @(posedge mclk);
        cycStart <= 1'b0;
        for (k = 0; k < 30; k++)
        begin
            @(negedge mclk);
            if (waitInsert === 1'b1)
                tw++;
            if (cycDone === 1'b1)
                break;
        end
        check_bit("cycle end", 1'b1, cycDone);
        check_count("cycle state", int'(BSC_ST_T3), int'(busState));
        check_count("wait states", expTw, tw);
    endtask

    function automatic int exp_tw(input int m, input int c, input int n);
        case (m)
            0: return c;
            2: return (n > c) ? n : c;
            3: return (n > 0) ? c : 0;
            default: return 0;
        endcase
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        #(20000 * 25);
        n_fail++;
        summarize();
    end

    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rstn = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        hwStandbyN = 1'b1;
        cycStart = 1'b0;
        cycExternal = 1'b0;
        lowCount = 3'h0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        bus_access(1'b0, `BSC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg("reset value", 32'h0000_0008, rd);
        @(negedge mclk);
        check_bit("tick undivided", 1'b1, periphTick);
        $display("test reset done");
        bus_access(1'b1, `BSC_CTRL_ADDR, 8'hA5, 4'hF, rd);
        bus_access(1'b0, `BSC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg("readback A5", 32'h0000_00A5, rd);
        check_bit("ram select", 1'b1, emuRamSelect);
        check_bit("ram area", 1'b0, emuRamArea);
        check_bit("clock halve", 1'b1, periphClockHalve);
        check_bit("flash enable", 1'b0, flashRegsEnable);
        @(negedge mclk);
        t0 = periphTick;
        @(negedge mclk);
        check_bit("tick halved", ~t0, periphTick);
        bus_access(1'b1, `BSC_CTRL_ADDR + 18'h4, 8'h00, 4'hF, rd);
        bus_access(1'b1, `BSC_CTRL_ADDR, 8'h00, 4'hE, rd);
        bus_access(1'b0, `BSC_CTRL_ADDR + 18'h4, 8'h00, 4'hF, rd);
        check_reg("unmapped read", 32'h0000_0000, rd);
        bus_access(1'b0, `BSC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg("refused writes", 32'h0000_00A5, rd);
        bus_access(1'b1, `BSC_CTRL_ADDR, 8'h5A, 4'hF, rd);
        bus_access(1'b0, `BSC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg("readback 5A", 32'h0000_005A, rd);
        check_bit("flash enable set", 1'b1, flashRegsEnable);
        check_bit("ram area set", 1'b1, emuRamArea);
        @(posedge mclk);
        hwStandbyN <= 1'b0;
        @(posedge mclk);
        hwStandbyN <= 1'b1;
        bus_access(1'b0, `BSC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg("standby reload", 32'h0000_0008, rd);
        $display("test register done");
        // Every mode and count, with fast, short and long requests from the far side
        for (int m = 0; m < 4; m++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                bus_access(1'b1, `BSC_CTRL_ADDR, 8'(m * 4 + c), 4'hF, rd);
                foreach (lows[i])
                    bus_cycle(1'b1, lows[i], exp_tw(m, c, lows[i]));
                bus_cycle(1'b0, 5, 0);
            end
        end
        $display("test wait modes done");
        summarize();
    end

endmodule // test_external_bus_wait_state_control

`default_nettype wire
